//--- hw/dtc_pkg.sv
/*
  Shared constants for the dual timer/counter: register offsets, bit positions,
  reset values and mode encodings.
  Assumes byte-wide registers, one per aligned 32-bit Wishbone word.
*/
package dtc_pkg;
  // Register byte addresses; the control/status offset is fixed, the rest are placed beside it
  localparam logic [7:0] DTC_ADR_CONTROL_STATUS = 8'h88;
  localparam logic [7:0] DTC_ADR_MODE = 8'h8C;
  localparam logic [7:0] DTC_ADR_AUX_MODE = 8'h90;
  localparam logic [7:0] DTC_ADR_T0_LOW = 8'h94;
  localparam logic [7:0] DTC_ADR_T0_HIGH = 8'h98;
  localparam logic [7:0] DTC_ADR_T1_LOW = 8'h9C;
  localparam logic [7:0] DTC_ADR_T1_HIGH = 8'hA0;
  localparam logic [7:0] DTC_ADR_AUX_CTRL = 8'hA4;
  // Control/status bits
  localparam int DTC_BIT_IT0 = 0;
  localparam int DTC_BIT_IE0 = 1;
  localparam int DTC_BIT_IT1 = 2;
  localparam int DTC_BIT_IE1 = 3;
  localparam int DTC_BIT_RUN0 = 4;
  localparam int DTC_BIT_OVF0 = 5;
  localparam int DTC_BIT_RUN1 = 6;
  localparam int DTC_BIT_OVF1 = 7;
  // Mode register: low nibble timer 0, high nibble timer 1
  localparam int DTC_MODE_GATE = 3;
  localparam int DTC_MODE_CT = 2;
  localparam int DTC_MODE_NIBBLE = 4;
  // Auxiliary mode: third mode bit per timer; auxiliary control: toggle enables
  localparam int DTC_AUX_M2_T0 = 0;
  localparam int DTC_AUX_M2_T1 = 4;
  localparam int DTC_TOG_EN_T0 = 0;
  localparam int DTC_TOG_EN_T1 = 1;
  localparam logic [7:0] DTC_RESET_BYTE = 8'h00;
  localparam logic [7:0] DTC_PWM_HIGH = 8'h00;
  localparam logic [7:0] DTC_PWM_LOW = 8'hFF;
  localparam logic [4:0] DTC_PRESCALE_TOP = 5'h1F;
  localparam logic [31:0] DTC_UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [2:0] {
    DTC_M13 = 3'b000,
    DTC_M16 = 3'b001,
    DTC_MRELOAD = 3'b010,
    DTC_MSPLIT = 3'b011,
    DTC_MPWM = 3'b110
  } dtc_mode_type;
endpackage

//--- hw/dtc_edge_sync.sv
/*
  Two-stage synchroniser with falling-edge pulse output.
  Assumes the pin is asynchronous to clk_i; the first stage feeds only the second.
*/
`timescale 1ns/1ns
module dtc_edge_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin
  input wire logic pin_i,
  // Synchronised level and falling-edge pulse
  output logic level_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic prev;

  // Resets to high so an idle-high pin gives no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign fall_o = prev & ~sync;
endmodule

//--- hw/dtc_prescale.sv
/*
  Low and high counter byte step logic for one timer.
  Assumes the caller holds the byte and applies the result only when the count enable is high.
*/
`timescale 1ns/1ns
module dtc_prescale import dtc_pkg::*; (
  // Mode and current bytes
  input wire logic [2:0] mode_i,
  input wire logic [7:0] low_i,
  input wire logic [7:0] high_i,
  // Next bytes and overflow
  output logic [7:0] next_low_o,
  output logic [7:0] next_high_o,
  output logic ovf_o
);
  wire is13 = (mode_i == DTC_M13);
  wire is16 = (mode_i == DTC_M16);
  // PWM lets the low byte wrap freely, so the period stays 256 clocks whatever the high byte holds
  wire reload = (mode_i == DTC_MRELOAD);
  wire low_wrap13 = (low_i[4:0] == DTC_PRESCALE_TOP);
  wire low_wrap8 = (low_i == DTC_PWM_LOW);
  wire carry = is13 ? low_wrap13 : low_wrap8;
  // 13-bit mode keeps the upper three low bits untouched; they carry no meaning
  wire [7:0] low13 = {low_i[7:5], low_i[4:0] + 5'h01};
  wire [7:0] low8 = low_i + 8'h01;

  assign next_low_o = is13 ? low13 : (reload && low_wrap8) ? high_i : low8;
  assign next_high_o = ((is13 || is16) && carry) ? high_i + 8'h01 : high_i;
  assign ovf_o = (is13 || is16) ? (carry && high_i == DTC_PWM_LOW) : low_wrap8;
endmodule

//--- hw/dtc_timer.sv
/*
  Dual timer/counter with 13-bit, 16-bit, auto-reload, split and PWM modes,
  toggle outputs and external interrupt flags, behind a classic Wishbone slave.
  Assumes pins synchronous-capable via internal synchronisers; single clock domain.
*/
`timescale 1ns/1ns
module dtc_timer import dtc_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic [1:0] count_pin_i,
  input wire logic [1:0] external_interrupt_pin_i,
  output logic [1:0] timer_pin_o,
  output logic [1:0] timer_pin_oe_o,
  // CPU interrupt logic
  input wire logic [1:0] ovf_service_i,
  input wire logic [1:0] ext_service_i,
  output logic [1:0] overflow_flag_o,
  output logic [1:0] ext_irq_o
);
  logic [7:0] timer_control_status;
  logic [7:0] timer_mode_register;
  logic [7:0] aux_mode;
  logic [7:0] auxiliary_control;
  logic [7:0] count_low_byte [2];
  logic [7:0] count_high_byte [2];
  logic [1:0] tog;
  logic [1:0] pwm_prev;
  logic [1:0] ext_prev;

  // Bus decode
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  wire rd = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_cs = wr && wb_adr_i == DTC_ADR_CONTROL_STATUS;
  wire wr_md = wr && wb_adr_i == DTC_ADR_MODE;
  wire wr_am = wr && wb_adr_i == DTC_ADR_AUX_MODE;
  wire wr_ac = wr && wb_adr_i == DTC_ADR_AUX_CTRL;
  wire [1:0] wr_lo = {wr && wb_adr_i == DTC_ADR_T1_LOW, wr && wb_adr_i == DTC_ADR_T0_LOW};
  wire [1:0] wr_hi = {wr && wb_adr_i == DTC_ADR_T1_HIGH, wr && wb_adr_i == DTC_ADR_T0_HIGH};

  wire [2:0] mode [2];
  assign mode[0] = {aux_mode[DTC_AUX_M2_T0], timer_mode_register[1:0]};
  assign mode[1] = {aux_mode[DTC_AUX_M2_T1], timer_mode_register[5:4]};
  wire split = (mode[0] == DTC_MSPLIT);

  wire [1:0] run = {timer_control_status[DTC_BIT_RUN1], timer_control_status[DTC_BIT_RUN0]};
  wire [1:0] ovf_flag = {timer_control_status[DTC_BIT_OVF1], timer_control_status[DTC_BIT_OVF0]};
  wire [1:0] ext_type = {timer_control_status[DTC_BIT_IT1], timer_control_status[DTC_BIT_IT0]};
  wire [1:0] ext_flag = {timer_control_status[DTC_BIT_IE1], timer_control_status[DTC_BIT_IE0]};
  wire [1:0] tog_en = {auxiliary_control[DTC_TOG_EN_T1], auxiliary_control[DTC_TOG_EN_T0]};

  wire [1:0] cnt_fall;
  wire [1:0] int_level;
  wire [1:0] int_fall;
  wire [1:0] count_en;
  wire [1:0] ovf;
  wire [1:0] pwm_out;
  wire [7:0] next_lo [2];
  wire [7:0] next_hi [2];
  wire [1:0] step_ovf;

  // Split high byte counts machine cycles under the timer 1 run bit; it wraps at 8 bits
  wire split_hi_en = split & run[1];
  wire split_hi_ovf = split_hi_en && count_high_byte[0] == DTC_PWM_LOW;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_timer
      wire [3:0] nib = timer_mode_register[DTC_MODE_NIBBLE*g +: DTC_MODE_NIBBLE];
      wire gated = ~nib[DTC_MODE_GATE] | int_level[g];
      wire src = nib[DTC_MODE_CT] ? cnt_fall[g] : 1'b1;
      // Timer 1 halts in its own mode 3; in split mode it keeps counting though its flag is taken
      wire stopped = (g == 1) && (mode[1] == DTC_MSPLIT);
      wire [2:0] eff_mode = (g == 0 && split) ? DTC_MRELOAD : mode[g];
      assign count_en[g] = run[g] & gated & src & ~stopped;

      dtc_edge_sync u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(count_pin_i[g]),
        .level_o(),
        .fall_o(cnt_fall[g])
      );
      dtc_edge_sync u_int (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(external_interrupt_pin_i[g]),
        .level_o(int_level[g]),
        .fall_o(int_fall[g])
      );
      dtc_prescale u_step (
        .mode_i(eff_mode),
        .low_i(count_low_byte[g]),
        .high_i(count_high_byte[g]),
        .next_low_o(next_lo[g]),
        .next_high_o(next_hi[g]),
        .ovf_o(step_ovf[g])
      );
      // Split low byte: plain 8-bit wrap, no reload
      wire [7:0] lo_val = (g == 0 && split) ? count_low_byte[g] + 8'h01 : next_lo[g];
      assign ovf[g] = count_en[g] & step_ovf[g];
      // PWM: flag low while low byte is below high byte, giving low time high-byte counts
      assign pwm_out[g] = count_low_byte[g] >= count_high_byte[g];

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          count_low_byte[g] <= DTC_RESET_BYTE;
        end else if (wr_lo[g]) begin
          count_low_byte[g] <= wb_dat_i[7:0];
        end else if (count_en[g]) begin
          count_low_byte[g] <= lo_val;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          count_high_byte[g] <= DTC_RESET_BYTE;
        end else if (wr_hi[g]) begin
          count_high_byte[g] <= wb_dat_i[7:0];
        end else if (g == 0 && split) begin
          if (split_hi_en) begin
            count_high_byte[g] <= count_high_byte[g] + 8'h01;
          end
        end else if (count_en[g]) begin
          count_high_byte[g] <= next_hi[g];
        end
      end

      // Toggle output: forced to one while disabled so it starts high
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tog[g] <= 1'b1;
        end else if (!tog_en[g]) begin
          tog[g] <= 1'b1;
        end else if (ovf[g] && !(g == 0 && split)) begin
          tog[g] <= ~tog[g];
        end else if (g == 0 && split && count_en[0] && count_low_byte[0] == DTC_PWM_LOW) begin
          tog[g] <= ~tog[g];
        end
      end

      // Pin drive: PWM level, or toggle output when enabled, in counter use as well
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          timer_pin_o[g] <= 1'b1;
          timer_pin_oe_o[g] <= 1'b0;
          pwm_prev[g] <= 1'b0;
        end else begin
          pwm_prev[g] <= pwm_out[g];
          if (mode[g] == DTC_MPWM) begin
            timer_pin_oe_o[g] <= 1'b1;
            if (count_high_byte[g] == DTC_PWM_HIGH) begin
              timer_pin_o[g] <= 1'b1;
            end else if (count_high_byte[g] == DTC_PWM_LOW) begin
              timer_pin_o[g] <= 1'b0;
            end else begin
              timer_pin_o[g] <= pwm_out[g];
            end
          end else begin
            // Toggling only makes sense on the internal clock; software keeps select clear
            timer_pin_oe_o[g] <= tog_en[g];
            // A disabled output shows one at once rather than a stale toggle level
            timer_pin_o[g] <= tog_en[g] ? tog[g] : 1'b1;
          end
        end
      end
    end
  endgenerate

  // Overflow events per flag: timer 1 flag is fed by the split high byte in mode 3
  wire split_lo_ovf = split & count_en[0] & (count_low_byte[0] == DTC_PWM_LOW);
  wire [1:0] ovf_evt = {split ? split_hi_ovf : ovf[1], split ? split_lo_ovf : ovf[0]};
  wire [1:0] is_pwm = {mode[1] == DTC_MPWM, mode[0] == DTC_MPWM};
  // PWM rise is the interrupt-worthy event; the flag follows the waveform otherwise
  wire [1:0] pwm_rise = pwm_out & ~pwm_prev;

  // External interrupt request: edge flag in edge mode, inverted level in level mode
  wire [1:0] ext_req = ext_type & int_fall;

  logic [7:0] next_cs;
  always_comb begin
    next_cs = timer_control_status;
    if (wr_cs) begin
      next_cs = wb_dat_i[7:0];
    end
    // Hardware clears on service first, so a set in the same cycle wins
    if (ext_service_i[0]) begin
      next_cs[DTC_BIT_IE0] = 1'b0;
    end
    if (ext_service_i[1]) begin
      next_cs[DTC_BIT_IE1] = 1'b0;
    end
    // PWM flags ignore the vector clear; the waveform owns them there
    if (ovf_service_i[0] && !is_pwm[0]) begin
      next_cs[DTC_BIT_OVF0] = 1'b0;
    end
    if (ovf_service_i[1] && !is_pwm[1]) begin
      next_cs[DTC_BIT_OVF1] = 1'b0;
    end
    if (ext_req[0]) begin
      next_cs[DTC_BIT_IE0] = 1'b1;
    end
    if (ext_req[1]) begin
      next_cs[DTC_BIT_IE1] = 1'b1;
    end
    // PWM: hardware drives the flag with the waveform, software writes still clear it
    if (is_pwm[0] && count_en[0] && pwm_out[0] != pwm_prev[0]) begin
      next_cs[DTC_BIT_OVF0] = pwm_rise[0];
    end
    if (is_pwm[1] && count_en[1] && pwm_out[1] != pwm_prev[1]) begin
      next_cs[DTC_BIT_OVF1] = pwm_rise[1];
    end
    // Overflow sets last so it beats a software or service clear in the same cycle
    if (ovf_evt[0] && !is_pwm[0]) begin
      next_cs[DTC_BIT_OVF0] = 1'b1;
    end
    if (ovf_evt[1] && !is_pwm[1]) begin
      next_cs[DTC_BIT_OVF1] = 1'b1;
    end
  end

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    case (wb_adr_i)
      DTC_ADR_CONTROL_STATUS: rd_byte = timer_control_status;
      DTC_ADR_MODE: rd_byte = timer_mode_register;
      DTC_ADR_AUX_MODE: rd_byte = aux_mode;
      DTC_ADR_T0_LOW: rd_byte = count_low_byte[0];
      DTC_ADR_T0_HIGH: rd_byte = count_high_byte[0];
      DTC_ADR_T1_LOW: rd_byte = count_low_byte[1];
      DTC_ADR_T1_HIGH: rd_byte = count_high_byte[1];
      DTC_ADR_AUX_CTRL: rd_byte = auxiliary_control;
      default: rd_byte = DTC_RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_status <= DTC_RESET_BYTE;
      timer_mode_register <= DTC_RESET_BYTE;
      aux_mode <= DTC_RESET_BYTE;
      auxiliary_control <= DTC_RESET_BYTE;
    end else begin
      timer_control_status <= next_cs;
      if (wr_md) begin
        timer_mode_register <= wb_dat_i[7:0];
      end
      // Unused auxiliary bits read back as zero
      if (wr_am) begin
        aux_mode <= wb_dat_i[7:0] & 8'h11;
      end
      if (wr_ac) begin
        auxiliary_control <= wb_dat_i[7:0] & 8'h03;
      end
    end
  end

  // One-wait-state slave; every address acks, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= DTC_UNMAPPED_DATA;
    end else begin
      wb_ack_o <= rd;
      wb_dat_o <= rd ? {24'h00_0000, rd_byte} : DTC_UNMAPPED_DATA;
    end
  end

  // Interrupt lines to the CPU
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_o <= 2'b00;
      ext_irq_o <= 2'b00;
    end else begin
      overflow_flag_o <= {next_cs[DTC_BIT_OVF1], next_cs[DTC_BIT_OVF0]};
      ext_irq_o <= (ext_type & {next_cs[DTC_BIT_IE1], next_cs[DTC_BIT_IE0]}) | (~ext_type & ~int_level);
    end
  end
endmodule

//--- bench/dtc_timer_props.sv
/*
  Concurrent checks on the dual timer ports, bound into dtc_timer.
  Assumes one clock and a synchronous active-high reset; software-only fields are shadowed from bus writes.
*/
`timescale 1ns/1ns
module dtc_timer_props import dtc_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic [1:0] external_interrupt_pin_i,
  input wire logic [1:0] timer_pin_o,
  input wire logic [1:0] ext_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow fields that hardware never changes, except th0, which hardware holds only in auto-reload and PWM; it is used in PWM
  logic [7:0] mode;
  logic [7:0] amode;
  logic [7:0] th0;
  logic [7:0] actl;
  logic it0;
  wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  wire pwm0 = {amode[0], mode[1:0]} == 3'h6;
  wire pin0 = external_interrupt_pin_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {mode, amode, th0, actl, it0} <= '0;
    end else if (wr) begin
      if (wb_adr_i == DTC_ADR_MODE) mode <= wb_dat_i[7:0];
      if (wb_adr_i == DTC_ADR_AUX_MODE) amode <= wb_dat_i[7:0];
      if (wb_adr_i == DTC_ADR_T0_HIGH) th0 <= wb_dat_i[7:0];
      if (wb_adr_i == DTC_ADR_AUX_CTRL) actl <= wb_dat_i[7:0];
      if (wb_adr_i == DTC_ADR_CONTROL_STATUS) it0 <= wb_dat_i[0];
    end
  end
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_tog_idle;
    (!actl[0] && !pwm0) [*2] |-> timer_pin_o[0];
  endproperty
  a_tog_idle: assert property (p_tog_idle) else $error("idle toggle pin not high");
  property p_lvl_on;
    (!it0 && !pin0) [*5] |-> ext_irq_o[0];
  endproperty
  a_lvl_on: assert property (p_lvl_on) else $error("level request missing");
  property p_lvl_off;
    (!it0 && pin0) [*5] |-> !ext_irq_o[0];
  endproperty
  a_lvl_off: assert property (p_lvl_off) else $error("level request without low pin");
  property p_edge;
    it0 && $fell(pin0) ##1 (it0 && !pin0) [*3] |-> ##[0:3] ext_irq_o[0];
  endproperty
  a_edge: assert property (p_edge) else $error("falling edge not flagged");
  property p_pwm_hi;
    (pwm0 && th0 == 8'h00) [*3] |-> timer_pin_o[0];
  endproperty
  a_pwm_hi: assert property (p_pwm_hi) else $error("pwm pin not forced high");
  property p_pwm_lo;
    (pwm0 && th0 == 8'hFF) [*3] |-> !timer_pin_o[0];
  endproperty
  a_pwm_lo: assert property (p_pwm_lo) else $error("pwm pin not forced low");
endmodule

bind dtc_timer dtc_timer_props dtc_timer_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .external_interrupt_pin_i(external_interrupt_pin_i), .timer_pin_o(timer_pin_o),
  .ext_irq_o(ext_irq_o));

//--- bench/dtc_cpu_model.sv
/*
  CPU interrupt logic model: answers a pending request with a one-cycle service pulse.
  Assumes the request is a level that drops once serviced; delay_i sets how slow it answers.
*/
`timescale 1ns/1ns
module dtc_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests and answer
  input wire logic [1:0] req_i,
  input wire logic [1:0] en_i,
  input wire logic [3:0] delay_i,
  output logic [1:0] ack_o
);
  logic [3:0] cnt [2];
  // Counter parks past the delay so a request still standing is not serviced twice
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      ack_o[i] <= !rst_i && req_i[i] && en_i[i] && cnt[i] == delay_i;
      if (rst_i || !req_i[i] || !en_i[i]) begin
        cnt[i] <= 4'h0;
      end else if (cnt[i] <= delay_i) begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
endmodule

//--- bench/dual_timer_counter_modes_tb_top.sv
/*
  Self-checking bench for the dual timer: Wishbone register tasks, pin stimulus, CPU service model.
  Assumes the package, the service model and the checker bind are compiled first.
*/
`timescale 1ns/1ns
module dual_timer_counter_modes_tb_top import dtc_pkg::*; ;
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [31:0] dw;
  logic [31:0] dr;
  logic [31:0] r;
  logic ack;
  logic [1:0] cpin, epin, tpin, tpoe, osv, esv, oflag, eirq, oen, een;
  int miscompares;
  int total_checks;
  int n;
  dtc_timer dtc_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .count_pin_i(cpin),
    .external_interrupt_pin_i(epin), .timer_pin_o(tpin), .timer_pin_oe_o(tpoe), .ovf_service_i(osv),
    .ext_service_i(esv), .overflow_flag_o(oflag), .ext_irq_o(eirq));
  dtc_cpu_model ovf_cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(oflag), .en_i(oen), .delay_i(4'h3), .ack_o(osv));
  dtc_cpu_model ext_cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(eirq), .en_i(een), .delay_i(4'h0), .ack_o(esv));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    r = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (k >= 20) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(r, {24'h00_0000, e});
  endtask
  // Counts edges in n until the flag shows v; a long wait means a hung timer
  task automatic wf(input int i, input logic v);
    n = 0;
    while (oflag[i] !== v && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      close_out();
    end
  endtask
  initial begin
    miscompares = 0;
    total_checks = 0;
    rst_i = 1'b1;
    {cyc, stb, we, adr, dw} = '0;
    {cpin, epin, oen, een} = 8'hF0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(DTC_ADR_CONTROL_STATUS, 8'h00);
    wr(8'hFC, 8'hFF);
    rd(8'hFC, 8'h00);
    chk(32'(tpin), 32'h0000_0003);
    chk(32'(tpoe), 32'h0000_0000);
    wr(DTC_ADR_T0_HIGH, 8'hFF);
    wr(DTC_ADR_T0_LOW, 8'h1E);
    wr(DTC_ADR_AUX_CTRL, 8'h01);
    chk(32'(tpin[0]), 32'h0000_0001);
    wr(DTC_ADR_CONTROL_STATUS, 8'h10);
    wf(0, 1'b1);
    chk(32'(n < 8), 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk(32'(tpin[0]), 32'h0000_0000);
    rd(DTC_ADR_CONTROL_STATUS, 8'h30);
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    rd(DTC_ADR_T0_HIGH, 8'h00);
    wr(DTC_ADR_MODE, 8'h09);
    epin <= 2'b10;
    wr(DTC_ADR_T0_LOW, 8'h40);
    wr(DTC_ADR_CONTROL_STATUS, 8'h10);
    repeat (10) @(posedge clk_i);
    rd(DTC_ADR_T0_LOW, 8'h40);
    epin <= 2'b11;
    repeat (20) @(posedge clk_i);
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    bus(1'b0, DTC_ADR_T0_LOW, 8'h00);
    chk(32'(r[7:0] > 8'h50), 32'h0000_0001);
    wr(DTC_ADR_T0_HIGH, 8'hF0);
    wr(DTC_ADR_T0_LOW, 8'hFE);
    wr(DTC_ADR_MODE, 8'h02);
    wr(DTC_ADR_CONTROL_STATUS, 8'h10);
    wf(0, 1'b1);
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    rd(DTC_ADR_T0_HIGH, 8'hF0);
    bus(1'b0, DTC_ADR_T0_LOW, 8'h00);
    chk(32'(r[7:4]), 32'h0000_000F);
    rd(DTC_ADR_CONTROL_STATUS, 8'h00);
    oen <= 2'b01;
    wr(DTC_ADR_T0_LOW, 8'hFE);
    wr(DTC_ADR_CONTROL_STATUS, 8'h10);
    wf(0, 1'b1);
    wf(0, 1'b0);
    chk(32'(n < 10), 32'h0000_0001);
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    wr(DTC_ADR_T1_LOW, 8'h10);
    wr(DTC_ADR_T0_HIGH, 8'hF8);
    wr(DTC_ADR_MODE, 8'h33);
    wr(DTC_ADR_CONTROL_STATUS, 8'h50);
    wf(1, 1'b1);
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    rd(DTC_ADR_T1_LOW, 8'h10);
    wr(DTC_ADR_MODE, 8'h13);
    wr(DTC_ADR_T1_HIGH, 8'hFF);
    wr(DTC_ADR_T1_LOW, 8'hFE);
    wr(DTC_ADR_CONTROL_STATUS, 8'h40);
    repeat (10) @(posedge clk_i);
    rd(DTC_ADR_CONTROL_STATUS, 8'h40);
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    rd(DTC_ADR_T1_HIGH, 8'h00);
    wr(DTC_ADR_AUX_CTRL, 8'h00);
    wr(DTC_ADR_MODE, 8'h02);
    wr(DTC_ADR_AUX_MODE, 8'h01);
    wr(DTC_ADR_T0_HIGH, 8'h40);
    wr(DTC_ADR_CONTROL_STATUS, 8'h10);
    wf(0, 1'b0);
    wf(0, 1'b1);
    wf(0, 1'b0);
    chk(n, 32'h0000_00C0);
    wf(0, 1'b1);
    chk(n, 32'h0000_0040);
    wr(DTC_ADR_T0_HIGH, 8'hFF);
    n = 0;
    repeat (260) begin
      @(posedge clk_i);
      n += int'(tpin[0] !== 1'b0);
    end
    chk(n, 32'h0000_0000);
    chk(32'(tpoe[0]), 32'h0000_0001);
    wr(DTC_ADR_T0_HIGH, 8'h00);
    chk(32'(tpin[0]), 32'h0000_0001);
    oen <= 2'b00;
    wr(DTC_ADR_AUX_MODE, 8'h00);
    wr(DTC_ADR_MODE, 8'h00);
    wr(DTC_ADR_CONTROL_STATUS, 8'h01);
    epin <= 2'b10;
    repeat (6) @(posedge clk_i);
    rd(DTC_ADR_CONTROL_STATUS, 8'h03);
    chk(32'(eirq[0]), 32'h0000_0001);
    wr(DTC_ADR_CONTROL_STATUS, 8'h01);
    rd(DTC_ADR_CONTROL_STATUS, 8'h01);
    een <= 2'b01;
    epin <= 2'b11;
    repeat (4) @(posedge clk_i);
    epin <= 2'b10;
    repeat (8) @(posedge clk_i);
    rd(DTC_ADR_CONTROL_STATUS, 8'h01);
    een <= 2'b00;
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    repeat (5) @(posedge clk_i);
    chk(32'(eirq[0]), 32'h0000_0001);
    rd(DTC_ADR_CONTROL_STATUS, 8'h00);
    epin <= 2'b11;
    repeat (5) @(posedge clk_i);
    chk(32'(eirq[0]), 32'h0000_0000);
    wr(DTC_ADR_MODE, 8'h05);
    wr(DTC_ADR_T0_LOW, 8'h00);
    wr(DTC_ADR_CONTROL_STATUS, 8'h10);
    repeat (5) begin
      cpin <= 2'b10;
      repeat (4) @(posedge clk_i);
      cpin <= 2'b11;
      repeat (4) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
    wr(DTC_ADR_CONTROL_STATUS, 8'h00);
    rd(DTC_ADR_T0_LOW, 8'h05);
    close_out();
  end
endmodule
